// [uep_pkg.sv]
// Constants and carrier types shared by the USB endpoint block.
package uep_pkg;

  // Register indices; the Wishbone byte address is four times the low 30 bits of the index.
  localparam logic [31:0] IDX_EP2_CFG  = 32'h5000_1858;
  localparam logic [31:0] IDX_RX1_DATA = 32'h5000_185A;
  localparam logic [31:0] IDX_RX1_STAT = 32'h5000_185C;
  localparam logic [31:0] IDX_RX1_CTRL = 32'h5000_185E;
  localparam logic [31:0] IDX_EP_CTRL  = 32'h5000_1870;

  // Register width and reset value.
  localparam int unsigned REG_W     = 16;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Endpoint configuration fields.
  localparam int unsigned CFG_STALL = 7;
  localparam int unsigned CFG_ISO   = 5;
  localparam int unsigned CFG_EN    = 4;
  localparam int unsigned EP_W      = 4;

  // Receive status fields.
  localparam int unsigned STS_ERR   = 7;
  localparam int unsigned STS_SETUP = 6;
  localparam int unsigned STS_TOG   = 5;
  localparam int unsigned STS_LAST  = 4;
  localparam int unsigned CNT_W     = 4;
  localparam logic [3:0]  CNT_MAX   = 4'hF;

  // Receive control and general control fields.
  localparam int unsigned RXC_FLUSH = 3;
  localparam int unsigned RXC_EN    = 0;
  localparam int unsigned CTL_TEST  = 0;
  localparam int unsigned CTL_ISO1  = 1;
  localparam int unsigned CTL_TX2   = 2;
  localparam int unsigned CTL_RX2   = 3;

  // Receive FIFO depth; a power of two.
  localparam int unsigned FIFO_DEPTH = 64;

  typedef enum logic [1:0] {TOK_IN, TOK_OUT, TOK_SETUP} uep_pid_t;
  typedef enum logic [2:0] {
    RSP_NONE, RSP_DATA, RSP_ACCEPT, RSP_NAK, RSP_STALL
  } uep_rsp_kind_t;
  typedef enum logic {RX_IDLE, RX_BUSY} uep_rx_state_t;

  typedef struct packed {
    logic       valid;
    uep_pid_t   pid;
    logic [6:0] addr;
    logic [3:0] endp;
  } uep_token_t;

  typedef struct packed {
    logic          valid;
    uep_rsp_kind_t kind;
  } uep_rsp_t;

  typedef struct packed {
    logic       valid;
    logic       setup;
    logic [7:0] data;
  } uep_byte_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic setup;
    logic data1;
  } uep_pkt_end_t;

  // Byte count as software sees it, held at its maximum.
  function automatic logic [3:0] uep_sat(input logic [31:0] n);
    return (n > 32'(CNT_MAX)) ? CNT_MAX : n[3:0];
  endfunction

endpackage

// [uep_rx_fifo.sv]
// Receive FIFO holding payload bytes of one endpoint.
`timescale 1ns/100ps
module uep_rx_fifo #(
  parameter int unsigned DW    = 8,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = $clog2(DEPTH),
  parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          sys_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          ce_i,
  input  wire logic          push_i,
  input  wire logic [DW-1:0] push_data_i,
  input  wire logic          pop_i,
  input  wire logic          flush_i,
  output logic      [DW-1:0] rd_data_o,
  output logic      [CW-1:0] count_o,
  output logic               full_o
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW-1:0]            wp;
    logic [AW-1:0]            rp;
    logic [CW-1:0]            cnt;
  } uep_fifo_st_t;

  uep_fifo_st_t q, d;
  logic do_push, do_pop;

  // Pointers wrap naturally, so DEPTH must be a power of two.
  always_comb begin
    d = q;
    do_push = push_i && (q.cnt != CW'(DEPTH));
    do_pop  = pop_i && (q.cnt != '0);
    if (flush_i) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end else begin
      if (do_push) begin
        d.mem[q.wp] = push_data_i;
        d.wp = q.wp + 1'b1;
      end
      if (do_pop) begin
        d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + CW'(do_push) - CW'(do_pop);
    end
  end

  // State register; reset and clock enable act on the whole copy.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign rd_data_o = q.mem[q.rp];
  assign count_o   = q.cnt;
  assign full_o    = (q.cnt == CW'(DEPTH));

  a_fifo_flush_empty: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && flush_i |=> count_o == '0)
    else $error("Flush did not empty the FIFO.");

  a_fifo_bounded: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    count_o <= CW'(DEPTH))
    else $error("FIFO count above depth.");

endmodule

// [uep_endpoint.sv]
// USB endpoint configuration, receive data port and receive status.
`timescale 1ns/100ps
module uep_endpoint
  import uep_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic [6:0]   function_address_i,
  input  wire logic         frame_number_lsb_i,
  input  wire uep_token_t   token_i,
  input  wire logic         ep2_tx_ready_i,
  input  wire logic         ep2_rx_full_i,
  input  wire logic         ep2_tx_sent_i,
  input  wire logic         ep2_rx_done_i,
  output uep_rsp_t          ep2_rsp_o,
  input  wire uep_byte_t    ep1_byte_i,
  input  wire uep_pkt_end_t ep1_pkt_i,
  output logic              ep1_rx_enable_o
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic          ack;
    logic [15:0]   rdat;
    logic          stall;
    logic          iso;
    logic          en;
    logic [3:0]    epnum;
    logic          tx2;
    logic          rx2;
    logic          test;
    logic          iso1;
    logic          rx1_en;
    logic          flush_pend;
    logic          err;
    logic          setup;
    logic          tog;
    logic          last;
    uep_rx_state_t rx_st;
    uep_rsp_t      rsp;
  } uep_st_t;

  uep_st_t q, d;

  logic          bus_req, tok_hit, st_rd, dat_rd, ctl_wr, rxc_wr;
  logic          push, pop, flush;
  logic [7:0]    pdata, fifo_rd;
  logic [CW-1:0] fifo_cnt;
  logic          fifo_full;
  uep_rsp_kind_t kind;

  // Full word-address compare, so no register aliases elsewhere.
  function automatic logic hit(input logic [31:0] adr,
                               input logic [31:0] idx);
    return adr[31:2] == idx[29:0];
  endfunction

  // Handshake choice for a token that matched this endpoint.
  function automatic uep_rsp_kind_t decide(input uep_pid_t pid,
      input logic stall, input logic iso, input logic tx,
      input logic rx, input logic rdy, input logic full);
    uep_rsp_kind_t k;
    k = RSP_NONE;
    case (pid)
      TOK_SETUP: k = RSP_ACCEPT;
      TOK_IN: begin
        if (stall && tx) k = RSP_STALL;
        else if (tx && rdy) k = RSP_DATA;
        else if (!iso) k = RSP_NAK;
      end
      TOK_OUT: begin
        if (stall && rx) k = RSP_STALL;
        else if (rx && !full) k = RSP_ACCEPT;
        else if (!iso) k = RSP_NAK;
      end
      default: k = RSP_NONE;
    endcase
    return k;
  endfunction

  // Request decode; a held request is answered once, then released.
  assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  assign st_rd   = bus_req && !wb_we_i && hit(wb_adr_i, IDX_RX1_STAT);
  assign dat_rd  = bus_req && !wb_we_i && hit(wb_adr_i, IDX_RX1_DATA);
  assign ctl_wr  = bus_req && wb_we_i && wb_sel_i[0]
                   && hit(wb_adr_i, IDX_EP_CTRL);
  assign rxc_wr  = bus_req && wb_we_i && wb_sel_i[0]
                   && hit(wb_adr_i, IDX_RX1_CTRL);

  // Token match on endpoint number and device address.
  assign tok_hit = token_i.valid && q.en
                   && token_i.addr == function_address_i
                   && token_i.endp == q.epnum;
  assign kind = decide(token_i.pid, q.stall, q.iso, q.tx2, q.rx2,
                       ep2_tx_ready_i, ep2_rx_full_i);

  // Next-state logic: tx2/rx2 clears, then bus access, then hardware
  // sets, so a flag set in the cycle of its clear is kept, except rx1_en and flush_pend, cleared last.
  always_comb begin
    d = q;
    push  = 1'b0;
    pop   = 1'b0;
    flush = 1'b0;
    pdata = ep1_byte_i.data;
    d.ack = 1'b0;
    d.rsp = '{valid: 1'b0, kind: RSP_NONE};
    if (tok_hit) begin
      d.rsp = '{valid: kind != RSP_NONE, kind: kind};
    end
    if (ep2_tx_sent_i || (tok_hit && token_i.pid == TOK_IN
        && kind == RSP_STALL)) begin
      d.tx2 = 1'b0;
    end
    if (ep2_rx_done_i || (tok_hit && token_i.pid == TOK_OUT
        && kind == RSP_STALL)) begin
      d.rx2 = 1'b0;
    end
    if (bus_req) begin
      d.ack  = 1'b1;
      d.rdat = REG_RESET;
      if (hit(wb_adr_i, IDX_EP2_CFG)) begin
        d.rdat = {8'h00, q.stall, 1'b0, q.iso, q.en, q.epnum};
        if (wb_we_i && wb_sel_i[0]) begin
          d.stall = wb_dat_i[CFG_STALL];
          d.iso   = wb_dat_i[CFG_ISO];
          d.en    = wb_dat_i[CFG_EN];
          d.epnum = wb_dat_i[EP_W-1:0];
        end
      end else if (hit(wb_adr_i, IDX_RX1_DATA)) begin
        d.rdat = {8'h00, fifo_rd};
        pop    = !wb_we_i;
        // A full FIFO drops the byte; the check keeps that intent local.
        if (wb_we_i && wb_sel_i[0] && q.test && !fifo_full) begin
          push  = 1'b1;
          pdata = wb_dat_i[7:0];
        end
      end else if (hit(wb_adr_i, IDX_RX1_STAT)) begin
        d.rdat = {8'h00, q.err, q.setup, q.tog, q.last,
                  uep_sat(32'(fifo_cnt))};
        if (!wb_we_i) begin
          d.setup = 1'b0;
          d.tog   = 1'b0;
          d.last  = 1'b0;
        end
      end else if (hit(wb_adr_i, IDX_RX1_CTRL)) begin
        d.rdat = {12'h000, q.flush_pend, 2'b00, q.rx1_en};
        if (rxc_wr) begin
          d.rx1_en = wb_dat_i[RXC_EN];
          if (wb_dat_i[RXC_FLUSH]) d.flush_pend = 1'b1;
        end
      end else if (hit(wb_adr_i, IDX_EP_CTRL)) begin
        d.rdat = {12'h000, q.rx2, q.tx2, q.iso1, q.test};
        if (ctl_wr) begin
          d.test = wb_dat_i[CTL_TEST];
          d.iso1 = wb_dat_i[CTL_ISO1];
          d.tx2  = wb_dat_i[CTL_TX2];
          d.rx2  = wb_dat_i[CTL_RX2];
        end
      end
    end
    // Payload from the receiver; SETUP data is taken even when disabled.
    if (ep1_byte_i.valid) begin
      d.rx_st = RX_BUSY;
      if (q.rx1_en || ep1_byte_i.setup) begin
        push  = 1'b1;
        pdata = ep1_byte_i.data;
      end
    end
    if (ep1_pkt_i.valid) begin
      d.rx_st = RX_IDLE;
      if (ep1_pkt_i.ok) begin
        d.last = 1'b1;
        d.tog  = q.iso1 ? frame_number_lsb_i
                        : ep1_pkt_i.data1;
        if (ep1_pkt_i.setup) d.setup = 1'b1;
        else d.rx1_en = 1'b0;
      end else begin
        d.err = 1'b1;
      end
    end
    // A pending flush waits for the packet in flight to finish.
    if (q.flush_pend && q.rx_st == RX_IDLE && !ep1_byte_i.valid
        && !ep1_pkt_i.valid) begin
      flush        = 1'b1;
      d.flush_pend = 1'b0;
      d.err        = 1'b0;
      push         = 1'b0;
    end
  end

  // State register; everything clears to zero under reset.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  uep_rx_fifo #(
    .DW    (8),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .push_i      (push),
    .push_data_i (pdata),
    .pop_i       (pop),
    .flush_i     (flush),
    .rd_data_o   (fifo_rd),
    .count_o     (fifo_cnt),
    .full_o      (fifo_full)
  );

  // Outputs come straight from the state register.
  assign wb_ack_o        = q.ack;
  assign wb_dat_o        = {16'h0000, q.rdat};
  assign ep2_rsp_o       = q.rsp;
  assign ep1_rx_enable_o = q.rx1_en;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_in_stall;
    ce_i && tok_hit && token_i.pid == TOK_IN && q.stall && q.tx2;
  endsequence

  sequence s_stall_out;
    ep2_rsp_o.valid && ep2_rsp_o.kind == RSP_STALL;
  endsequence

  a_in_stall_reply: assert property (s_in_stall |=> s_stall_out)
    else $error("IN token to stalled endpoint not stalled.");

  a_in_stall_txoff: assert property (
    !ctl_wr ##0 s_in_stall |=> !q.tx2)
    else $error("Transmit enable kept after IN stall.");

  a_ep2_tx_sent_clr: assert property (
    ce_i && ep2_tx_sent_i && !ctl_wr |=> !q.tx2)
    else $error("Transmit enable kept after packet sent.");

  a_ep2_rx_done_clr: assert property (
    ce_i && ep2_rx_done_i && !ctl_wr |=> !q.rx2)
    else $error("Receive enable kept after packet received.");

  a_out_stall_reply: assert property (
    ce_i && tok_hit && token_i.pid == TOK_OUT && q.stall && q.rx2
    |=> s_stall_out)
    else $error("OUT token to stalled endpoint not stalled.");

  a_setup_no_stall: assert property (
    ce_i && tok_hit && token_i.pid == TOK_SETUP
    |=> ep2_rsp_o.valid && ep2_rsp_o.kind == RSP_ACCEPT)
    else $error("SETUP token not accepted.");

  a_iso_no_nak: assert property (
    ce_i && q.iso |=> ep2_rsp_o.kind != RSP_NAK)
    else $error("Isochronous endpoint sent NAK.");

  a_disabled_silent: assert property (
    ce_i && !q.en |=> !ep2_rsp_o.valid)
    else $error("Disabled endpoint answered a token.");

  a_setup_flag_set: assert property (
    ce_i && ep1_pkt_i.valid && ep1_pkt_i.ok && ep1_pkt_i.setup
    |=> q.setup && q.last)
    else $error("SETUP packet did not set its flags.");

  a_read_clears_tog: assert property (
    ce_i && st_rd && !ep1_pkt_i.valid |=> !q.tog && !q.setup)
    else $error("Status read left flags set.");

  a_count_saturates: assert property (
    ce_i && st_rd |=> wb_ack_o
    && wb_dat_o[3:0] == uep_sat(32'($past(fifo_cnt))))
    else $error("Status byte count wrong.");

  a_pop_one_byte: assert property (
    ce_i && dat_rd && !push && !flush && fifo_cnt != '0
    |=> fifo_cnt == CW'($past(fifo_cnt) - 1'b1))
    else $error("Data read did not remove one byte.");

  a_flush_deferred: assert property (
    q.rx_st == RX_BUSY |-> !flush)
    else $error("Flush during reception.");

  a_rx_stops: assert property (
    ce_i && ep1_pkt_i.valid && ep1_pkt_i.ok && !ep1_pkt_i.setup
    && !rxc_wr |=> !ep1_rx_enable_o)
    else $error("Reception not stopped after data packet.");

endmodule

// [uep_host_model.sv]
// Host-side model that sends tokens and endpoint-1 packets to the block.
`timescale 1ns/100ps
module uep_host_model
  import uep_pkg::*;
(
  input  wire logic    sys_clk_i,
  input  wire uep_rsp_t rsp_i,
  output uep_token_t   token_o,
  output uep_byte_t    byte_o,
  output uep_pkt_end_t pkt_o
);
  // The bus starts idle.
  initial begin
    token_o = '0;
    byte_o = '0;
    pkt_o = '0;
  end

  // One token, then the answer taken in the one cycle that it stands.
  task automatic send_token(input uep_pid_t p, input logic [6:0] a,
                            input logic [3:0] e, output uep_rsp_t r);
    @(posedge sys_clk_i);
    token_o <= '{valid: 1'b1, pid: p, addr: a, endp: e};
    @(posedge sys_clk_i);
    token_o.valid <= 1'b0;
    token_o.addr  <= ~a; // A released field must not look held.
    @(posedge sys_clk_i);
    r = rsp_i;
  endtask

  // Payload bytes only, then one end-of-packet pulse after the last byte.
  task automatic send_pkt(input int n, input logic [7:0] b0,
                          input logic s, input logic d1, input logic good);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      byte_o <= '{valid: 1'b1, setup: s, data: b0 + 8'(i)};
    end
    @(posedge sys_clk_i);
    byte_o.valid <= 1'b0;
    byte_o.data  <= ~byte_o.data;
    pkt_o <= '{valid: 1'b1, ok: good, setup: s, data1: d1};
    @(posedge sys_clk_i);
    pkt_o.valid <= 1'b0;
    @(posedge sys_clk_i);
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the USB endpoint block.
`timescale 1ns/100ps
module tb_top
  import uep_pkg::*;
;
  logic         sys_clk_i = 1'b0;
  logic         rst       = 1'b1;
  logic         cyc       = 1'b0;
  logic         stb       = 1'b0;
  logic         we        = 1'b0;
  logic [31:0]  adr       = 32'h0000_0000;
  logic [31:0]  dat_w     = 32'h0000_0000;
  logic [31:0]  dat_r;
  logic         ack;
  logic [6:0]   fa        = 7'h15;
  logic         fn_lsb    = 1'b0;
  logic         tx_rdy    = 1'b1;
  logic         rx_full   = 1'b0;
  logic         ce        = 1'b1;
  logic [3:0]   sel       = 4'h0;
  logic [3:0]   sel_use   = 4'hF;
  logic         tx_sent   = 1'b0;
  logic         rx_done   = 1'b0;
  uep_token_t   tok;
  uep_rsp_t     rsp;
  uep_byte_t    byte_s;
  uep_pkt_end_t pkt;
  logic         rx_en;
  logic [15:0]  r;
  uep_rsp_t     q;
  int           err_count = 0;
  int           num_checks = 0;

  // Free-running 100 MHz clock.
  always #5 sys_clk_i = ~sys_clk_i;

  uep_endpoint uut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(rst), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .function_address_i(fa), .frame_number_lsb_i(fn_lsb), .token_i(tok),
    .ep2_tx_ready_i(tx_rdy), .ep2_rx_full_i(rx_full),
    .ep2_tx_sent_i(tx_sent), .ep2_rx_done_i(rx_done), .ep2_rsp_o(rsp),
    .ep1_byte_i(byte_s), .ep1_pkt_i(pkt), .ep1_rx_enable_o(rx_en));

  uep_host_model host (
    .sys_clk_i(sys_clk_i), .rsp_i(rsp), .token_o(tok), .byte_o(byte_s),
    .pkt_o(pkt));

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Kind is only judged when an answer is expected.
  task automatic cmp_rsp(input uep_rsp_t g, input logic v,
                         input uep_rsp_kind_t k);
    cmp({12'h000, g.valid, v ? g.kind : RSP_NONE},
        {12'h000, v, v ? k : RSP_NONE});
  endtask

  // Classic single cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [31:0] idx,
                    input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge sys_clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    sel   <= sel_use;
    adr   <= {idx[29:0], 2'b00};
    dat_w <= {16'h0000, wd};
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      final_report();
    end
    rd = dat_r[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic wr(input logic [31:0] idx, input logic [15:0] v);
    wb(1'b1, idx, v, r);
  endtask

  task automatic rdr(input logic [31:0] idx);
    wb(1'b0, idx, 16'h0000, r);
  endtask

  // Flush waits out any reception, so poll the pending bit with a bound.
  task automatic flush();
    int n;
    wr(IDX_RX1_CTRL, 16'h0008);
    for (n = 0; n < 20; n++) begin
      rdr(IDX_RX1_CTRL);
      if (r[RXC_FLUSH] === 1'b0) break;
    end
    if (n == 20) begin
      err_count++;
      final_report();
    end
  endtask

  task automatic t_regs();
    cmp({15'h0000, rx_en}, 16'h0000);
    rdr(IDX_EP2_CFG);
    cmp(r, REG_RESET);
    rdr(IDX_RX1_STAT);
    cmp(r, REG_RESET);
    wr(IDX_EP2_CFG, 16'h00FF);
    rdr(IDX_EP2_CFG);
    cmp(r, 16'h00BF);
    // A write without the low byte lane must leave the register alone.
    sel_use = 4'hE;
    wr(IDX_EP2_CFG, 16'h0000);
    sel_use = 4'hF;
    rdr(IDX_EP2_CFG);
    cmp(r, 16'h00BF);
    rdr(32'h5000_1900);
    cmp(r, 16'h0000);
  endtask

  task automatic t_tokens();
    wr(IDX_EP2_CFG, 16'h0012);
    wr(IDX_EP_CTRL, 16'h000C);
    host.send_token(TOK_IN, 7'h15, 4'h3, q);
    cmp_rsp(q, 1'b0, RSP_NONE);
    host.send_token(TOK_IN, 7'h14, 4'h2, q);
    cmp_rsp(q, 1'b0, RSP_NONE);
    host.send_token(TOK_IN, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b1, RSP_DATA);
    wr(IDX_EP2_CFG, 16'h0092);
    wr(IDX_EP_CTRL, 16'h000C);
    host.send_token(TOK_IN, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b1, RSP_STALL);
    rdr(IDX_EP_CTRL);
    cmp(r & 16'h0004, 16'h0000);
    host.send_token(TOK_OUT, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b1, RSP_STALL);
    host.send_token(TOK_SETUP, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b1, RSP_ACCEPT);
    wr(IDX_EP2_CFG, 16'h0002);
    wr(IDX_EP_CTRL, 16'h000C);
    host.send_token(TOK_IN, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b0, RSP_NONE);
    wr(IDX_EP2_CFG, 16'h0032);
    tx_rdy  <= 1'b0;
    rx_full <= 1'b1;
    host.send_token(TOK_IN, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b0, RSP_NONE);
    host.send_token(TOK_OUT, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b0, RSP_NONE);
    wr(IDX_EP2_CFG, 16'h0012);
    host.send_token(TOK_IN, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b1, RSP_NAK);
    // A frozen block must not answer; once running again it must.
    ce <= 1'b0;
    host.send_token(TOK_IN, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b0, RSP_NONE);
    ce <= 1'b1;
    host.send_token(TOK_IN, 7'h15, 4'h2, q);
    cmp_rsp(q, 1'b1, RSP_NAK);
    tx_rdy  <= 1'b1;
    rx_full <= 1'b0;
    // A sent packet clears only its transmit enable; a received packet then clears the receive enable.
    wr(IDX_EP_CTRL, 16'h000C);
    tx_sent <= 1'b1;
    @(posedge sys_clk_i);
    tx_sent <= 1'b0;
    rdr(IDX_EP_CTRL);
    cmp(r & 16'h000C, 16'h0008);
    rx_done <= 1'b1;
    @(posedge sys_clk_i);
    rx_done <= 1'b0;
    rdr(IDX_EP_CTRL);
    cmp(r & 16'h000C, 16'h0000);
  endtask

  task automatic t_rx();
    wr(IDX_RX1_CTRL, 16'h0001);
    host.send_pkt(3, 8'h10, 1'b0, 1'b1, 1'b1);
    rdr(IDX_RX1_STAT);
    cmp(r, 16'h0033);
    cmp({15'h0000, rx_en}, 16'h0000);
    rdr(IDX_RX1_STAT);
    cmp(r, 16'h0003);
    rdr(IDX_RX1_DATA);
    cmp(r, 16'h0010);
    rdr(IDX_RX1_STAT);
    cmp(r, 16'h0002);
    rdr(IDX_RX1_DATA);
    cmp(r, 16'h0011);
    rdr(IDX_RX1_DATA);
    cmp(r, 16'h0012);
    rdr(IDX_RX1_STAT);
    cmp(r, 16'h0000);
  endtask

  // Setup bytes enter even with reception off; 17 bytes saturate at 15.
  task automatic t_setup();
    host.send_pkt(17, 8'h40, 1'b1, 1'b0, 1'b1);
    rdr(IDX_RX1_STAT);
    cmp(r & 16'h004F, 16'h004F);
    rdr(IDX_RX1_STAT);
    cmp(r & 16'h0040, 16'h0000);
    flush();
    rdr(IDX_RX1_STAT);
    cmp(r, 16'h0000);
  endtask

  task automatic t_err();
    wr(IDX_RX1_CTRL, 16'h0001);
    host.send_pkt(2, 8'h60, 1'b0, 1'b0, 1'b0);
    rdr(IDX_RX1_STAT);
    cmp(r & 16'h0080, 16'h0080);
    flush();
    rdr(IDX_RX1_STAT);
    cmp(r, 16'h0000);
  endtask

  task automatic t_iso();
    wr(IDX_EP_CTRL, 16'h0002);
    wr(IDX_RX1_CTRL, 16'h0001);
    fn_lsb <= 1'b1;
    host.send_pkt(1, 8'h70, 1'b0, 1'b0, 1'b1);
    rdr(IDX_RX1_STAT);
    cmp(r & 16'h0020, 16'h0020);
    rdr(IDX_RX1_STAT);
    cmp(r & 16'h0020, 16'h0000);
    flush();
  endtask

  task automatic t_test();
    wr(IDX_EP_CTRL, 16'h0001);
    wr(IDX_RX1_DATA, 16'h00A5);
    rdr(IDX_RX1_STAT);
    cmp(r, 16'h0001);
    rdr(IDX_RX1_DATA);
    cmp(r, 16'h00A5);
    wr(IDX_EP_CTRL, 16'h0000);
  endtask

  // Reset for eight cycles, then each scenario in turn.
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst <= 1'b0;
    t_regs();
    t_tokens();
    t_rx();
    t_setup();
    t_err();
    t_iso();
    t_test();
    final_report();
  end
endmodule
